// ===== src/dbrrc_pkg.sv
// Constants, types and register map for the drive busy/reset/retry control
package dbrrc_pkg;

	// ---------------------------------------------------------------
	// Register map (word index, byte address = 4 * index)
	// ---------------------------------------------------------------
	localparam logic [3:0] DBRRC_IDX_DATA    = 4'h0;
	localparam logic [3:0] DBRRC_IDX_ERROR   = 4'h1;
	localparam logic [3:0] DBRRC_IDX_SECCNT  = 4'h2;
	localparam logic [3:0] DBRRC_IDX_SECNUM  = 4'h3;
	localparam logic [3:0] DBRRC_IDX_CYLLO   = 4'h4;
	localparam logic [3:0] DBRRC_IDX_CYLHI   = 4'h5;
	localparam logic [3:0] DBRRC_IDX_DRVHEAD = 4'h6;
	localparam logic [3:0] DBRRC_IDX_STATUS  = 4'h7;
	localparam logic [3:0] DBRRC_IDX_ALTSTAT = 4'h8;
	localparam logic [3:0] DBRRC_IDX_DIGOUT  = 4'h9;
	localparam logic [3:0] DBRRC_IDX_MPU     = 4'hA;
	localparam logic [3:0] DBRRC_IDX_MECH    = 4'hB;
	localparam logic [3:0] DBRRC_IDX_RETRY   = 4'hC;
	localparam logic [3:0] DBRRC_IDX_ECC     = 4'hD;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int DBRRC_ST_BUSY  = 7;
	localparam int DBRRC_ST_READY = 6;
	localparam int DBRRC_ST_SEEK  = 4;
	localparam int DBRRC_ST_DRQ   = 3;
	localparam int DBRRC_ST_ERR   = 0;
	localparam int DBRRC_DO_SRST  = 2;

	// MPU control register bits (write)
	localparam int DBRRC_MPU_SET_BUSY  = 0;
	localparam int DBRRC_MPU_CLR_BUSY  = 1;
	localparam int DBRRC_MPU_CLR_DRQ   = 2;
	localparam int DBRRC_MPU_SPUNDOWN  = 3;
	localparam int DBRRC_MPU_LAST_XFER = 4;
	localparam int DBRRC_MPU_BUF_FULL  = 5;

	// Mechanism control bits (write)
	localparam int DBRRC_MX_SPIN_DONE  = 0;
	localparam int DBRRC_MX_MEM_DONE   = 1;
	localparam int DBRRC_MX_RD_FAIL    = 2;
	localparam int DBRRC_MX_RD_OK      = 3;
	localparam int DBRRC_MX_HDR_FAIL   = 4;
	localparam int DBRRC_MX_HDR_OK     = 5;
	localparam int DBRRC_MX_RETRY_DIS  = 6;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] DBRRC_RST_ERROR  = 8'h01;
	localparam logic [7:0] DBRRC_RST_SECCNT = 8'h01;
	localparam logic [7:0] DBRRC_RST_SECNUM = 8'h01;
	localparam logic [7:0] DBRRC_RST_ZERO   = 8'h00;

	// ---------------------------------------------------------------
	// Commands, retry and ECC figures
	// ---------------------------------------------------------------
	localparam logic [7:0] DBRRC_CMD_MASK   = 8'hF0;
	localparam logic [7:0] DBRRC_CMD_READ   = 8'h20;
	localparam logic [7:0] DBRRC_CMD_WRITE  = 8'h30;
	localparam logic [7:0] DBRRC_CMD_FORMAT = 8'h50;
	localparam logic [7:0] DBRRC_CMD_WRBUF  = 8'hE8;
	localparam int DBRRC_RETRY_STEPS  = 16;
	localparam int DBRRC_RETRY_PASSES = 8;
	localparam int DBRRC_HDR_RETRIES  = 20;
	localparam int DBRRC_SEG1_BYTES   = 245;
	localparam int DBRRC_SEG2_BYTES   = 267;
	localparam int DBRRC_SECTOR_BYTES = 512;
	localparam int DBRRC_LONG_ECC     = 7;
	localparam int DBRRC_BURST_BITS   = 8;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam longint DBRRC_CLK_HZ        = 50000000;
	localparam longint DBRRC_READY_TMO_MS  = 10000;
	localparam longint DBRRC_READY_TMO_CYC =
		DBRRC_READY_TMO_MS * (DBRRC_CLK_HZ / 1000);
	localparam longint DBRRC_IF_INIT_US    = 4000;
	localparam longint DBRRC_IF_INIT_CYC   =
		DBRRC_IF_INIT_US * (DBRRC_CLK_HZ / 1000000);

	// Retry step actions
	typedef enum logic [2:0]
	{
		DBRRC_ACT_READ   = 3'h0,
		DBRRC_ACT_ECC    = 3'h1,
		DBRRC_ACT_OFFP   = 3'h2,
		DBRRC_ACT_OFFN   = 3'h3,
		DBRRC_ACT_WIN1   = 3'h4,
		DBRRC_ACT_THRESH = 3'h5,
		DBRRC_ACT_WIN2   = 3'h6,
		DBRRC_ACT_NOM    = 3'h7
	} dbrrc_act_type;

	typedef enum logic [4:0]
	{
		DBRRC_S_OFF    = 5'b00001,
		DBRRC_S_MEMTST = 5'b00010,
		DBRRC_S_IFINIT = 5'b00100,
		DBRRC_S_SPIN   = 5'b01000,
		DBRRC_S_RUN    = 5'b10000
	} dbrrc_state_type;

	typedef struct packed
	{
		logic          active;
		logic          failed;
		dbrrc_act_type action;
		logic [3:0]    step;
		logic [2:0]    pass;
	} dbrrc_retry_type;

endpackage : dbrrc_pkg

// ===== src/dbrrc_top.sv
// Drive busy latch, reset sequencing, read and header retry control
//
// Functional notes
// - Power-on runs memory tests before spin-up starts.
// - After power-on, stay busy until spin-up, then ready and seek complete.
// - If spun down before, drop busy with ready set, no spin-up wait.
// - Ten second timer limits spin-up wait; expiry drops busy, not ready.
// - Late spin-up completion after time-out still sets ready and seek.
// - Host reset runs interface initialisation only, no tests or spin-up.
// - Host reset with disk spinning reaches ready, not busy in about 4 ms.
// - Memory test and spin-up last seconds; host must tolerate that.
// - Read command write sets busy on the same clock.
// - Write commands raise wide transfer and request; busy on buffer full.
// - Outside reset and spin-up, only the microprocessor clears busy; it may also set it.
// - While busy, host reads of any task register except digital output return status.
// - While not busy, host reads and writes every task register.
// - Data read error runs 16 steps, up to 8 passes, stops on success.
// - Steps: ECC, +offset, -offset, windows, threshold, nominal restore.
// - With retries disabled, exactly one retry before the error.
// - Header ECC error allows up to twenty rereads, then header error.
// - Header read good before the limit clears the header counter.
// - Header retry count is fixed and not host alterable.
// - Sector ECC split into 245 and 267 byte segments, 8-bit bursts.
// - Long read returns 512 data bytes then 7 ECC bytes.
// - Reset loads task defaults and drops busy with no interrupt.
// - Software reset holds while the reset bit stays one.
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/100ps

module dbrrc_top
	import dbrrc_pkg::*;
#(
	parameter longint READY_TMO_CYC = DBRRC_READY_TMO_CYC,
	parameter longint IF_INIT_CYC   = DBRRC_IF_INIT_CYC
)
(
	input  wire logic        clk_i,              // 50 MHz clock
	input  wire logic        rst_n_i,            // Power-on reset, low
	input  wire logic        host_rst_n_i,       // Host hardware reset pin
	input  wire logic [5:0]  avs_address,        // Word address
	input  wire logic        avs_read,           // Read request
	input  wire logic        avs_write,          // Write request
	input  wire logic [31:0] avs_writedata,      // Write data
	input  wire logic [3:0]  avs_byteenable,     // Byte lanes
	output logic [31:0]      avs_readdata,       // Read data
	output logic             avs_waitrequest,    // Stall
	output logic             busy_flag_o,        // Busy latch
	output logic             transfer_request_flag_o, // Data request
	output logic             wide_transfer_enable_o,  // 16-bit enable
	output logic             spin_start_o,       // Spin motor request
	output logic [7:0]       retry_ctl_o         // Active retry step
);

	// Counts must fit the 36-bit timer and reach its end value
	if (READY_TMO_CYC < 2 || IF_INIT_CYC < 2
		|| READY_TMO_CYC > 36'hF_FFFF_FFFF
		|| IF_INIT_CYC > 36'hF_FFFF_FFFF)
	begin : g_bad_count
		$error("dbrrc_top: time-out counts out of range");
	end

	// ---------------------------------------------------------------
	// Host reset pin synchroniser
	// ---------------------------------------------------------------
	logic hrst_meta_reg;
	logic hrst_sync_reg;
	logic hrst_prev_reg;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			hrst_meta_reg <= 1'b1;
			hrst_sync_reg <= 1'b1;
			hrst_prev_reg <= 1'b1;
		end
		else
		begin
			hrst_meta_reg <= host_rst_n_i;
			hrst_sync_reg <= hrst_meta_reg;
			hrst_prev_reg <= hrst_sync_reg;
		end
	end

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	logic [7:0]      err_reg, seccnt_reg, secnum_reg;
	logic [7:0]      cyllo_reg, cylhi_reg, drvhd_reg;
	logic [7:0]      cmd_reg, data_reg, digout_reg;
	logic            busy_reg, ready_reg, seek_reg, drq_reg, wide_reg;
	logic            spundown_reg, spin_start_reg, spin_ok_reg;
	logic            tmo_reg, retry_dis_reg, hdr_err_reg;
	logic [4:0]      hdr_cnt_reg;
	dbrrc_retry_type rty_reg;
	dbrrc_state_type state_reg;
	logic [35:0]     tmr_reg;
	logic [31:0]     rdata_reg;
	logic            ack_reg;

	wire        req      = (avs_read | avs_write) & ~ack_reg;
	wire [3:0]  idx      = avs_address[3:0];
	wire        hi_page  = avs_address[5:4] != 2'h0;
	wire        wr       = avs_write & req & avs_byteenable[0];
	wire [7:0]  wd       = avs_writedata[7:0];
	wire        mpu_acc  = idx == DBRRC_IDX_MPU || idx == DBRRC_IDX_MECH;
	// Host writes to task registers other than digital output are dropped while busy
	wire        host_wr  = wr & ~hi_page & ~busy_reg & ~mpu_acc;
	wire        wr_cmd   = wr & ~hi_page & idx == DBRRC_IDX_STATUS & ~busy_reg;
	wire        wr_dig   = wr & ~hi_page & idx == DBRRC_IDX_DIGOUT;
	wire        wr_mpu   = wr & ~hi_page & idx == DBRRC_IDX_MPU;
	wire        wr_mech  = wr & ~hi_page & idx == DBRRC_IDX_MECH;
	wire [7:0]  cmd_cls  = wd & DBRRC_CMD_MASK;
	wire        cmd_wrt  = cmd_cls == DBRRC_CMD_WRITE
		|| cmd_cls == DBRRC_CMD_FORMAT || wd == DBRRC_CMD_WRBUF;
	wire        cmd_rd   = wr_cmd & ~cmd_wrt;
	wire        cmd_wr   = wr_cmd & cmd_wrt;
	wire        srst     = digout_reg[DBRRC_DO_SRST];
	wire        hrst_rise = hrst_sync_reg & ~hrst_prev_reg;
	wire        srst_fall = wr_dig & srst & ~wd[DBRRC_DO_SRST];
	wire        host_rst  = ~hrst_sync_reg | (srst & ~srst_fall);
	wire        if_start  = hrst_rise | srst_fall;

	wire [7:0] status = {busy_reg, ready_reg, 1'b0, seek_reg,
		drq_reg, 2'h0, err_reg != 8'h00 && hdr_err_reg};

	// ---------------------------------------------------------------
	// Read mux; while busy every task read except digital output returns status
	// ---------------------------------------------------------------
	logic [7:0] task_rd;
	always_comb
	begin
		task_rd = 8'h00;
		if (idx == DBRRC_IDX_DATA)
			task_rd = data_reg;
		else if (idx == DBRRC_IDX_ERROR)
			task_rd = err_reg;
		else if (idx == DBRRC_IDX_SECCNT)
			task_rd = seccnt_reg;
		else if (idx == DBRRC_IDX_SECNUM)
			task_rd = secnum_reg;
		else if (idx == DBRRC_IDX_CYLLO)
			task_rd = cyllo_reg;
		else if (idx == DBRRC_IDX_CYLHI)
			task_rd = cylhi_reg;
		else if (idx == DBRRC_IDX_DRVHEAD)
			task_rd = drvhd_reg;
		else if (idx == DBRRC_IDX_STATUS || idx == DBRRC_IDX_ALTSTAT)
			task_rd = status;
		else if (idx == DBRRC_IDX_DIGOUT)
			task_rd = digout_reg;
	end

	logic [31:0] rd_next;
	always_comb
	begin
		rd_next = 32'h0000_0000;
		if (hi_page)
			rd_next = 32'h0000_0000;
		else if (idx == DBRRC_IDX_MPU)
			rd_next = {16'h0000, cmd_reg, status};
		else if (idx == DBRRC_IDX_MECH)
			rd_next = {24'h000000, 1'b0, retry_dis_reg, 1'b0,
				tmo_reg, 1'b0, spundown_reg, spin_ok_reg,
				state_reg == DBRRC_S_RUN};
		else if (idx == DBRRC_IDX_RETRY)
			rd_next = {8'h00, hdr_err_reg, 3'h0, hdr_cnt_reg, 3'h0,
				rty_reg};
		else if (idx == DBRRC_IDX_ECC)
			rd_next = {16'(DBRRC_SECTOR_BYTES + DBRRC_LONG_ECC),
				8'(DBRRC_SEG2_BYTES - DBRRC_SEG1_BYTES),
				8'(DBRRC_BURST_BITS)};
		else if (busy_reg && idx != DBRRC_IDX_DIGOUT)
			rd_next = {24'h000000, status};
		else
			rd_next = {24'h000000, task_rd};
	end

	// ---------------------------------------------------------------
	// Bus answer: one wait state, then ack
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end
		else
		begin
			ack_reg   <= req;
			rdata_reg <= req ? rd_next : rdata_reg;
		end
	end

	// ---------------------------------------------------------------
	// Reset and spin-up sequencer
	// ---------------------------------------------------------------
	wire mem_done  = wr_mech & wd[DBRRC_MX_MEM_DONE];
	wire spin_done = wr_mech & wd[DBRRC_MX_SPIN_DONE];
	wire tmr_end   = tmr_reg == 36'h0_0000_0001;
	logic init_done;
	assign init_done = state_reg == DBRRC_S_IFINIT && tmr_end;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_reg      <= DBRRC_S_MEMTST;
			tmr_reg        <= 36'h0_0000_0000;
			spin_start_reg <= 1'b0;
			spin_ok_reg    <= 1'b0;
			tmo_reg        <= 1'b0;
		end
		else
		begin
			if (tmr_reg != 36'h0_0000_0000)
				tmr_reg <= tmr_reg - 36'h0_0000_0001;
			if (spin_done)
				spin_ok_reg <= 1'b1;
			case (state_reg)
			DBRRC_S_MEMTST:
				if (mem_done)
				begin
					spin_start_reg <= ~spundown_reg;
					state_reg      <= DBRRC_S_IFINIT;
					tmr_reg        <= 36'(IF_INIT_CYC);
				end
			DBRRC_S_IFINIT:
				if (tmr_end)
				begin
					// Spun-down drive goes straight to run
					if (spin_ok_reg || spundown_reg || spin_done)
						state_reg <= DBRRC_S_RUN;
					else
					begin
						state_reg <= DBRRC_S_SPIN;
						tmr_reg   <= 36'(READY_TMO_CYC);
					end
				end
			DBRRC_S_SPIN:
				if (spin_done)
					state_reg <= DBRRC_S_RUN;
				else if (tmr_end)
				begin
					tmo_reg   <= 1'b1;
					state_reg <= DBRRC_S_RUN;
				end
			DBRRC_S_RUN:
				if (host_rst)
					state_reg <= DBRRC_S_OFF;
			DBRRC_S_OFF:
				if (if_start)
				begin
					state_reg <= DBRRC_S_IFINIT;
					tmr_reg   <= 36'(IF_INIT_CYC);
				end
			default:
				state_reg <= DBRRC_S_OFF;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Busy latch, status bits and task file
	// ---------------------------------------------------------------
	wire mpu_set  = wr_mpu & wd[DBRRC_MPU_SET_BUSY];
	wire mpu_clr  = wr_mpu & wd[DBRRC_MPU_CLR_BUSY];
	wire buf_fill = wr_mpu & wd[DBRRC_MPU_BUF_FULL]
		& ~wd[DBRRC_MPU_LAST_XFER] & drq_reg;
	wire go_ready = init_done & (spin_ok_reg | spundown_reg | spin_done);
	wire late_ok  = spin_done & (tmo_reg | state_reg == DBRRC_S_SPIN);
	wire rst_hold = state_reg == DBRRC_S_OFF
		|| state_reg == DBRRC_S_MEMTST || state_reg == DBRRC_S_IFINIT;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			busy_reg     <= 1'b1;
			ready_reg    <= 1'b0;
			seek_reg     <= 1'b0;
			drq_reg      <= 1'b0;
			wide_reg     <= 1'b0;
			spundown_reg <= 1'b0;
			digout_reg   <= 8'h00;
			cmd_reg      <= 8'h00;
			data_reg     <= 8'h00;
			err_reg      <= DBRRC_RST_ERROR;
			seccnt_reg   <= DBRRC_RST_SECCNT;
			secnum_reg   <= DBRRC_RST_SECNUM;
			cyllo_reg    <= DBRRC_RST_ZERO;
			cylhi_reg    <= DBRRC_RST_ZERO;
			drvhd_reg    <= DBRRC_RST_ZERO;
		end
		else
		begin
			if (wr_dig)
				digout_reg <= wd;
			if (wr_mpu)
				spundown_reg <= wd[DBRRC_MPU_SPUNDOWN];
			if (rst_hold)
			begin
				busy_reg <= 1'b1;
				drq_reg  <= 1'b0;
				wide_reg <= 1'b0;
				if (host_rst)
				begin
					ready_reg <= 1'b0;
					seek_reg  <= 1'b0;
				end
				if (init_done)
				begin
					busy_reg   <= state_reg == DBRRC_S_IFINIT
						&& !(go_ready || spundown_reg);
					ready_reg  <= go_ready;
					seek_reg   <= go_ready;
					err_reg    <= DBRRC_RST_ERROR;
					seccnt_reg <= DBRRC_RST_SECCNT;
					secnum_reg <= DBRRC_RST_SECNUM;
					cyllo_reg  <= DBRRC_RST_ZERO;
					cylhi_reg  <= DBRRC_RST_ZERO;
					drvhd_reg  <= DBRRC_RST_ZERO;
				end
			end
			else
			begin
				if (state_reg == DBRRC_S_SPIN && tmr_end && !spin_done)
					busy_reg <= 1'b0;
				else if (cmd_rd || buf_fill || mpu_set)
					busy_reg <= 1'b1;
				else if (mpu_clr || (state_reg == DBRRC_S_SPIN && spin_done))
					busy_reg <= 1'b0;
				if (late_ok)
				begin
					ready_reg <= 1'b1;
					seek_reg  <= 1'b1;
				end
				if (cmd_wr)
				begin
					drq_reg  <= 1'b1;
					wide_reg <= 1'b1;
				end
				else if (wr_mpu && wd[DBRRC_MPU_CLR_DRQ])
				begin
					drq_reg  <= 1'b0;
					wide_reg <= 1'b0;
				end
				if (host_wr)
				begin
					if (idx == DBRRC_IDX_DATA)
						data_reg <= wd;
					else if (idx == DBRRC_IDX_ERROR)
						err_reg <= wd;
					else if (idx == DBRRC_IDX_SECCNT)
						seccnt_reg <= wd;
					else if (idx == DBRRC_IDX_SECNUM)
						secnum_reg <= wd;
					else if (idx == DBRRC_IDX_CYLLO)
						cyllo_reg <= wd;
					else if (idx == DBRRC_IDX_CYLHI)
						cylhi_reg <= wd;
					else if (idx == DBRRC_IDX_DRVHEAD)
						drvhd_reg <= wd;
					else if (idx == DBRRC_IDX_STATUS)
						cmd_reg <= wd;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Data and header retry sequencers
	// ---------------------------------------------------------------
	// Step table: the fixed sixteen-step recovery order
	function automatic dbrrc_act_type step_act(input logic [3:0] s);
		dbrrc_act_type a;
		a = DBRRC_ACT_READ;
		case (s)
		4'h2, 4'h4, 4'h6, 4'h9, 4'hC: a = DBRRC_ACT_ECC;
		4'h3:                         a = DBRRC_ACT_OFFP;
		4'h5:                         a = DBRRC_ACT_OFFN;
		4'h7:                         a = DBRRC_ACT_WIN1;
		4'h8:                         a = DBRRC_ACT_THRESH;
		4'hA, 4'hD:                   a = DBRRC_ACT_NOM;
		4'hB:                         a = DBRRC_ACT_WIN2;
		default:                      a = DBRRC_ACT_READ;
		endcase
		return a;
	endfunction : step_act

	wire rd_fail  = wr_mech & wd[DBRRC_MX_RD_FAIL];
	wire rd_ok    = wr_mech & wd[DBRRC_MX_RD_OK];
	wire hdr_fail = wr_mech & wd[DBRRC_MX_HDR_FAIL];
	wire hdr_ok   = wr_mech & wd[DBRRC_MX_HDR_OK];
	wire last_step = rty_reg.step == 4'(DBRRC_RETRY_STEPS - 1);
	wire last_pass = rty_reg.pass == 3'(DBRRC_RETRY_PASSES - 1);
	// Disabled retries allow only the single first retry step
	wire rty_end  = retry_dis_reg ? rty_reg.step == 4'h1
		: last_step & last_pass;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rty_reg       <= '0;
			retry_dis_reg <= 1'b0;
			hdr_cnt_reg   <= 5'h00;
			hdr_err_reg   <= 1'b0;
		end
		else
		begin
			if (wr_mech)
				retry_dis_reg <= wd[DBRRC_MX_RETRY_DIS];
			if (rd_ok)
			begin
				rty_reg <= '0;
			end
			else if (rd_fail && !rty_reg.failed)
			begin
				if (rty_end && rty_reg.active)
				begin
					rty_reg.active <= 1'b0;
					rty_reg.failed <= 1'b1;
				end
				else
				begin
					rty_reg.active <= 1'b1;
					rty_reg.step   <= rty_reg.step + 4'h1;
					rty_reg.action <= step_act(rty_reg.step + 4'h1);
					if (last_step)
						rty_reg.pass <= rty_reg.pass + 3'h1;
				end
			end
			// Fixed limit; nothing from the host reaches it
			if (hdr_ok)
			begin
				hdr_cnt_reg <= 5'h00;
				hdr_err_reg <= 1'b0;
			end
			else if (hdr_fail && !hdr_err_reg)
			begin
				if (hdr_cnt_reg == 5'(DBRRC_HDR_RETRIES))
					hdr_err_reg <= 1'b1;
				else
					hdr_cnt_reg <= hdr_cnt_reg + 5'h01;
			end
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign avs_readdata            = rdata_reg;
	assign avs_waitrequest         = ~ack_reg;
	assign busy_flag_o             = busy_reg;
	assign transfer_request_flag_o = drq_reg;
	assign wide_transfer_enable_o  = wide_reg;
	assign spin_start_o            = spin_start_reg;
	assign retry_ctl_o = {rty_reg.active, rty_reg.action, rty_reg.step};

endmodule : dbrrc_top

// ===== tb/dbrrc_asserts.sv
// Port assertions for busy, reset and command handling
`timescale 1ns/100ps
module dbrrc_asserts
(
	input wire logic        clk_i,           // Clock
	input wire logic        rst_n_i,         // Reset
	input wire logic        host_rst_n_i,    // Host reset
	input wire logic [5:0]  avs_address,     // Index
	input wire logic        avs_read,        // Read
	input wire logic        avs_write,       // Write
	input wire logic [31:0] avs_writedata,   // Data in
	input wire logic [3:0]  avs_byteenable,  // Lanes
	input wire logic [31:0] avs_readdata,    // Data out
	input wire logic        avs_waitrequest, // Stall
	input wire logic        busy_flag_o,     // Busy
	input wire logic        transfer_request_flag_o, // Request
	input wire logic        wide_transfer_enable_o,  // Wide
	input wire logic        spin_start_o     // Spin
);
	logic      mem_seen_reg;
	wire       wr_take = avs_write && avs_waitrequest && avs_byteenable[0];
	wire       rd_take = avs_read && avs_waitrequest;
	wire       cmd_take = wr_take && avs_address == 6'h07 && !busy_flag_o;
	wire [7:0] cmd = avs_writedata[7:0];
	wire       wr_cmd = cmd[7:4] == 4'h3 || cmd[7:4] == 4'h5 || cmd == 8'hE8;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	always_ff @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i)
			mem_seen_reg <= 1'b0;
		else if (wr_take && avs_address == 6'h0B && cmd[1])
			mem_seen_reg <= 1'b1;
	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	sequence s_init;
		busy_flag_o [*8] ##[1:300] !busy_flag_o;
	endsequence
	a_one_wait: assert property ((avs_read || avs_write) &&
		avs_waitrequest |=> !avs_waitrequest) else $error("no ack");
	a_read_cmd: assert property (cmd_take && cmd[7:4] == 4'h2
		|=> busy_flag_o) else $error("read command left busy low");
	a_write_cmd: assert property (cmd_take && wr_cmd |=> ##[0:1]
		transfer_request_flag_o && wide_transfer_enable_o)
		else $error("write command gave no request");
	a_write_idle: assert property (cmd_take && wr_cmd
		|=> !busy_flag_o [*2]) else $error("write command set busy");
	a_buf_full: assert property (wr_take && avs_address == 6'h0A &&
		cmd[5] && !cmd[4] && transfer_request_flag_o && !busy_flag_o
		|=> ##[0:1] busy_flag_o) else $error("buffer full kept idle");
	a_busy_read: assert property (rd_take && busy_flag_o &&
		avs_address < 6'h09 |=> avs_readdata[7])
		else $error("busy read not status");
	a_status_map: assert property (rd_take && !busy_flag_o &&
		avs_address == 6'h07 |=> !avs_readdata[7] &&
		avs_readdata[3] == $past(transfer_request_flag_o))
		else $error("status bits misplaced");
	// Two synchroniser stages and the state change come first
	a_host_busy: assert property (!host_rst_n_i [*5]
		|-> busy_flag_o) else $error("host reset without busy");
	a_host_init: assert property ($rose(host_rst_n_i)
		|-> s_init) else $error("interface init length wrong");
	a_no_respin: assert property (!host_rst_n_i
		|=> $stable(spin_start_o)) else $error("host reset moved spin");
	a_spin_order: assert property ($rose(spin_start_o)
		|-> mem_seen_reg) else $error("spin before memory tests");
endmodule : dbrrc_asserts

bind dbrrc_top dbrrc_asserts chk (.*);

// ===== tb/dbrrc_host.sv
// Host-side bus master and reset pin model
`timescale 1ns/100ps
module dbrrc_host
	import dbrrc_pkg::*;
(
	input  wire logic        clk_i,           // Clock
	input  wire logic [31:0] avs_readdata,    // Read data
	input  wire logic        avs_waitrequest, // Stall
	output logic             host_rst_n_o,    // Host reset pin
	output logic [5:0]       avs_address,     // Index
	output logic             avs_read,        // Read
	output logic             avs_write,       // Write
	output logic [31:0]      avs_writedata,   // Data
	output logic [3:0]       avs_byteenable   // Lanes
);
	initial
	begin
		host_rst_n_o = 1'b1;
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
	end
	// Released lines carry inverted values so stale data never matches
	task automatic xfer(input logic wr, input logic [5:0] a,
		input logic [7:0] d, output logic [31:0] q);
		@(posedge clk_i);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {24'h0, d};
		do
			@(posedge clk_i);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_address <= ~a;
		avs_writedata <= ~{24'h0, d};
	endtask : xfer
	task automatic pin_reset(input int n);
		@(posedge clk_i);
		host_rst_n_o <= 1'b0;
		repeat (n) @(posedge clk_i);
		host_rst_n_o <= 1'b1;
	endtask : pin_reset
endmodule : dbrrc_host

// ===== tb/dbrrc_bench.sv
// Self-checking bench for the drive busy, reset and retry control
`timescale 1ns/100ps
module dbrrc_bench;
	import dbrrc_pkg::*;
	logic        clk_i;
	logic        rst_n_i;
	wire         hrst_n;
	wire  [5:0]  adr;
	wire         rd;
	wire         wr;
	wire  [31:0] wd;
	wire  [3:0]  be;
	logic [31:0] rdata;
	logic        waitreq;
	logic        busy;
	logic        transfer_request_flag;
	logic        wide;
	logic        spin;
	logic [7:0]  rctl;
	logic [31:0] q;
	logic [7:0]  v;
	logic [7:0]  wcmd [3] = '{8'h30, 8'h50, 8'hE8};
	int          n;
	int          err_total;
	int          check_count;
	dbrrc_top #(.READY_TMO_CYC(200), .IF_INIT_CYC(20)) uut (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .host_rst_n_i(hrst_n), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wd),
		.avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(waitreq),
		.busy_flag_o(busy), .transfer_request_flag_o(transfer_request_flag),
		.wide_transfer_enable_o(wide), .spin_start_o(spin),
		.retry_ctl_o(rctl));
	dbrrc_host host (.clk_i(clk_i), .avs_readdata(rdata),
		.avs_waitrequest(waitreq), .host_rst_n_o(hrst_n), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wd),
		.avs_byteenable(be));
	initial clk_i = 1'b0;
	always #10 clk_i = ~clk_i;
	function automatic logic [7:0] stat(logic b, logic r, logic d);
		return {b, r, 1'b0, r, d, 3'b000};
	endfunction : stat
	task automatic chk(input string s, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic wnb(output int c);
		c = 0;
		while (busy !== 1'b0 && c < 400)
		begin
			@(posedge clk_i);
			c++;
		end
		#1;
	endtask : wnb
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test
	// Whole run needs about 600 cycles
	initial
	begin
		#400000;
		err_total++;
		end_of_test();
	end
	initial
	begin
		rst_n_i = 1'b0;
		err_total = 0;
		check_count = 0;
		void'($urandom(54));
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		host.xfer(1'b0, 6'h03, 8'h00, q);
		chk("busy read", 1, q[7]);
		host.xfer(1'b1, 6'h0B, 8'h02, q);
		wnb(n);
		chk("spin", 1, spin);
		host.xfer(1'b0, 6'h07, 8'h00, q);
		chk("timeout status", stat(0, 0, 0), q[7:0] & 8'hD8);
		host.xfer(1'b1, 6'h0B, 8'h01, q);
		host.xfer(1'b0, 6'h07, 8'h00, q);
		chk("late ready", stat(0, 1, 0), q[7:0] & 8'hD8);
		host.pin_reset(5);
		wnb(n);
		chk("init cycles", 1, n >= 20 && n < 40);
		chk("spin kept", 1, spin);
		for (int i = 1; i < 7; i++)
		begin
			host.xfer(1'b0, 6'(i), 8'h00, q);
			chk("default", (i < 4) ? 32'h1 : 32'h0, q);
		end
		repeat (4)
			for (int i = 2; i < 6; i++)
			begin
				v = 8'($urandom);
				host.xfer(1'b1, 6'(i), v, q);
				host.xfer(1'b0, 6'(i), 8'h00, q);
				chk("task reg", {24'h0, v}, q);
			end
		v = 8'($urandom);
		host.xfer(1'b1, 6'h04, v, q);
		host.xfer(1'b1, 6'h07, 8'h20 | 8'($urandom_range(15)), q);
		#1 chk("read cmd", 1, busy);
		host.xfer(1'b1, 6'h04, ~v, q);
		host.xfer(1'b0, 6'h05, 8'h00, q);
		chk("status alias", 1, q[7]);
		host.xfer(1'b1, 6'h0A, 8'h02, q);
		#1 chk("mpu clear", 0, busy);
		host.xfer(1'b0, 6'h04, 8'h00, q);
		chk("refused write", {24'h0, v}, q);
		foreach (wcmd[k])
		begin
			host.xfer(1'b1, 6'h07, wcmd[k], q);
			#1 chk("write cmd", 3'b110, {transfer_request_flag, wide, busy});
			host.xfer(1'b0, 6'h07, 8'h00, q);
			chk("drq status", stat(0, 1, 1), q[7:0] & 8'hD8);
			host.xfer(1'b1, 6'h0A, 8'h20, q);
			#1 chk("buffer full", 1, busy);
			host.xfer(1'b1, 6'h0A, 8'h06, q);
			#1 chk("mpu clear", 3'b000, {transfer_request_flag, wide, busy});
		end
		host.xfer(1'b1, 6'h09, 8'h04, q);
		repeat (30) @(posedge clk_i);
		#1 chk("soft reset held", 1, busy);
		host.xfer(1'b1, 6'h09, 8'h00, q);
		wnb(n);
		chk("soft reset done", 0, busy);
		repeat (20) host.xfer(1'b1, 6'h0B, 8'h10, q);
		host.xfer(1'b0, 6'h0C, 8'h00, q);
		chk("header count", 20, q[19:15]);
		chk("header early", 0, q[23]);
		host.xfer(1'b1, 6'h0B, 8'h10, q);
		host.xfer(1'b0, 6'h0C, 8'h00, q);
		chk("header error", 1, q[23]);
		host.xfer(1'b1, 6'h0B, 8'h20, q);
		host.xfer(1'b0, 6'h0C, 8'h00, q);
		chk("header clear", 0, q[19:15]);
		host.xfer(1'b1, 6'h0B, 8'h04, q);
		#1 chk("retry active", 1, rctl[7]);
		host.xfer(1'b1, 6'h0B, 8'h08, q);
		#1 chk("retry stop", 0, rctl[7]);
		host.xfer(1'b1, 6'h0B, 8'h44, q);
		host.xfer(1'b1, 6'h0B, 8'h44, q);
		#1 chk("retry once", 0, rctl[7]);
		host.xfer(1'b0, 6'h0D, 8'h00, q);
		chk("ecc info", 32'h0207_1608, q);
		end_of_test();
	end
endmodule : dbrrc_bench
